// ==== core/utx_dev.sv ====
// tx endpoint control and status logic, the documented device end
`timescale 1ns/1ps
module utx_dev (
   // clock and reset
   input wire logic clock_in,
   input wire logic resetn_in,
   // role and host settings
   input wire logic host_role_in,
   input wire logic host_bulk_in,
   input wire logic [7:0] tx_poll_interval_in,
   // register port
   input wire logic [1:0] reg_sel_in,
   input wire logic reg_wr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   // packet load and dma
   input wire logic load_valid_in,
   input wire logic [7:0] load_data_in,
   output logic load_ready_out,
   output logic dma_req_out,
   output logic tx_event_out,
   // usb link
   utx_link_if.dev link
);
   localparam int AW = utx_pkg::BUF_AW;

   // ************************************************
   // state
   // ************************************************
   logic [7:0] pkt_mem [0:utx_pkg::BUF_BYTES-1];
   utx_pkg::utx_state_t state_reg;
   logic [15:0] maxp_reg, rx_max_packet_reg;
   logic auto_reg, iso_reg, dir_reg, dma_en_reg, frc_reg, dma_mode_reg, stall_req_reg;
   logic incomp_reg, stall_flag_reg, under_reg, ready_reg, toggle_reg;
   logic [AW:0] cnt_reg, rd_ptr_reg, part_off_reg, part_end_reg;
   logic [1:0] err_cnt_reg;
   logic [7:0] nak_frames_reg;
   logic nak_seen_reg;

   logic q_valid, q_ready;
   logic [7:0] q_data;
   logic csr_wr, periph, idle, cpu_flush, cpu_ready, halted;
   logic ev_stall_tx, ev_under, start_p, start_h, send_end, more_parts;
   logic ev_done, ev_stall_rx, ev_nak, ev_none, ev_err, ev_incomp_p, ev_nak_to;
   logic flush_all, fill, fill_hit;
   logic [AW:0] part_limit, room_end;
   logic [15:0] csr_view;

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic [2:0] eff_mult(input logic [15:0] mp);
      eff_mult = {1'b0, mp[utx_pkg::MP_MULT_HI:utx_pkg::MP_MULT_LO]} + 3'h1;
   endfunction : eff_mult

   function automatic logic [AW:0] payload(input logic [15:0] mp);
      payload = {2'b00, mp[utx_pkg::MP_PAY_HI:0]};
   endfunction : payload

   function automatic logic [AW:0] full_size(input logic [15:0] mp);
      logic [13:0] prod;
      prod = 14'(payload(mp)) * 14'(eff_mult(mp));
      full_size = prod[AW:0];
   endfunction : full_size

   // ************************************************
   // byte queue in front of the packet buffer
   // ************************************************
   utx_fifo #(
      .WIDTH(utx_pkg::FIFO_WIDTH),
      .DEPTH(utx_pkg::FIFO_DEPTH)
   ) u_queue (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .clear_in(flush_all),
      .in_valid_in(load_valid_in),
      .in_data_in(load_data_in),
      .in_ready_out(load_ready_out),
      .out_valid_out(q_valid),
      .out_data_out(q_data),
      .out_ready_in(q_ready)
   );

   // ************************************************
   // event decode
   // ************************************************
   assign csr_wr = reg_wr_in && reg_sel_in == utx_pkg::REG_TX_CSR;
   assign cpu_flush = csr_wr && reg_wdata_in[utx_pkg::CSR_FLUSH];
   assign cpu_ready = csr_wr && reg_wdata_in[utx_pkg::CSR_READY];
   assign periph = !host_role_in;
   assign idle = state_reg == utx_pkg::ST_IDLE;
   assign halted = host_bulk_in && incomp_reg;
   assign room_end = part_off_reg + payload(maxp_reg);
   assign part_limit = (periph && iso_reg && room_end < cnt_reg) ? room_end : cnt_reg;

   always_comb begin
      ev_stall_tx = periph && idle && link.in_token && dir_reg && stall_req_reg;
      ev_under = periph && idle && link.in_token && dir_reg && !stall_req_reg && !ready_reg;
      start_p = periph && idle && link.in_token && dir_reg && !stall_req_reg && ready_reg;
      start_h = host_role_in && idle && dir_reg && ready_reg && !halted && !stall_flag_reg
         && !under_reg && !cpu_flush;
      send_end = state_reg == utx_pkg::ST_SEND && (rd_ptr_reg + 1'b1) >= part_end_reg;
      more_parts = periph && iso_reg && part_end_reg < cnt_reg;
      ev_done = (send_end && !more_parts && (frc_reg || (periph && iso_reg)))
         || (state_reg == utx_pkg::ST_WAIT && link.hs_ack);
      ev_stall_rx = host_role_in && state_reg == utx_pkg::ST_WAIT && link.hs_stall;
      ev_nak = host_role_in && state_reg == utx_pkg::ST_WAIT && link.hs_nak;
      ev_none = host_role_in && state_reg == utx_pkg::ST_WAIT && link.hs_none;
      ev_err = ev_none && err_cnt_reg == 2'(utx_pkg::ERR_LIMIT - 1);
      ev_incomp_p = periph && iso_reg && idle && link.frame_tick && part_off_reg != '0;
      // one-shot, otherwise a cpu clear of the timeout flag would never stick
      ev_nak_to = host_role_in && host_bulk_in && nak_seen_reg && tx_poll_interval_in != 8'h00
         && nak_frames_reg >= tx_poll_interval_in && !incomp_reg;
      flush_all = cpu_flush || ev_stall_tx || ev_stall_rx || ev_err || ev_incomp_p;
      q_ready = !ready_reg && !flush_all && !cpu_ready && cnt_reg < (AW + 1)'(utx_pkg::BUF_BYTES);
      fill = q_valid && q_ready;
      fill_hit = fill && auto_reg && (cnt_reg + 1'b1) == full_size(maxp_reg);
   end

   // ************************************************
   // software controlled settings
   // ************************************************
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         maxp_reg <= utx_pkg::MP_RESET;
         rx_max_packet_reg <= utx_pkg::MP_RESET;
         {auto_reg, iso_reg, dir_reg, dma_en_reg} <= 4'h0;
         {frc_reg, dma_mode_reg, stall_req_reg} <= 3'h0;
      end else if (reg_wr_in) begin
         if (reg_sel_in == utx_pkg::REG_TX_MAXP) maxp_reg <= reg_wdata_in & utx_pkg::MP_MASK;
         if (reg_sel_in == utx_pkg::REG_RX_MAXP) rx_max_packet_reg <= reg_wdata_in & utx_pkg::MP_MASK;
         if (csr_wr) begin
            auto_reg <= reg_wdata_in[utx_pkg::CSR_AUTO];
            iso_reg <= reg_wdata_in[utx_pkg::CSR_ISO];
            dir_reg <= reg_wdata_in[utx_pkg::CSR_DIR];
            dma_en_reg <= reg_wdata_in[utx_pkg::CSR_DMA_EN];
            frc_reg <= reg_wdata_in[utx_pkg::CSR_FRC_TOG];
            dma_mode_reg <= reg_wdata_in[utx_pkg::CSR_DMA_MODE];
            stall_req_reg <= reg_wdata_in[utx_pkg::CSR_STALL_REQ];
         end
      end
   end

   // ************************************************
   // sticky flags: hardware set wins over software clear
   // ************************************************
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         {incomp_reg, stall_flag_reg, under_reg} <= 3'h0;
      end else begin
         if (ev_incomp_p || (ev_none && !host_bulk_in) || ev_nak_to) begin
            incomp_reg <= 1'b1;
         end else if (csr_wr && !reg_wdata_in[utx_pkg::CSR_INCOMP]) begin
            incomp_reg <= 1'b0;
         end
         if (ev_stall_tx || ev_stall_rx) begin
            stall_flag_reg <= 1'b1;
         end else if (csr_wr && !reg_wdata_in[utx_pkg::CSR_STALL_FLAG]) begin
            stall_flag_reg <= 1'b0;
         end
         if (ev_under || ev_err) begin
            under_reg <= 1'b1;
         end else if (csr_wr && !reg_wdata_in[utx_pkg::CSR_UNDER]) begin
            under_reg <= 1'b0;
         end
      end
   end

   // ************************************************
   // packet ready and data toggle
   // ************************************************
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         ready_reg <= 1'b0;
         toggle_reg <= 1'b0;
      end else begin
         if (flush_all || ev_done) ready_reg <= 1'b0;
         else if (cpu_ready || fill_hit) ready_reg <= 1'b1;
         if (csr_wr && reg_wdata_in[utx_pkg::CSR_CLR_TOG]) toggle_reg <= 1'b0;
         else if (ev_done) toggle_reg <= !toggle_reg;
      end
   end

   // ************************************************
   // retry and nak bookkeeping
   // ************************************************
   always_ff @(posedge clock_in) begin
      if (!resetn_in || ev_done || flush_all || ev_nak) begin
         err_cnt_reg <= 2'h0;
      end else if (ev_none) begin
         err_cnt_reg <= err_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in || ev_done || flush_all
          || (csr_wr && !reg_wdata_in[utx_pkg::CSR_INCOMP])) begin
         nak_seen_reg <= 1'b0;
         nak_frames_reg <= 8'h00;
      end else begin
         if (ev_nak) nak_seen_reg <= 1'b1;
         if (nak_seen_reg && link.frame_tick && nak_frames_reg != 8'hff) begin
            nak_frames_reg <= nak_frames_reg + 8'h01;
         end
      end
   end

   // ************************************************
   // packet buffer fill
   // ************************************************
   always_ff @(posedge clock_in) begin
      if (fill) pkt_mem[cnt_reg[AW-1:0]] <= q_data;
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in || flush_all || ev_done) begin
         cnt_reg <= '0;
      end else if (fill) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // ************************************************
   // transaction sequencing
   // ************************************************
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         state_reg <= utx_pkg::ST_IDLE;
         rd_ptr_reg <= '0;
         part_off_reg <= '0;
         part_end_reg <= '0;
      end else if (flush_all) begin
         state_reg <= utx_pkg::ST_IDLE;
         part_off_reg <= '0;
      end else begin
         case (state_reg)
            utx_pkg::ST_IDLE: begin
               if (start_p || start_h) begin
                  rd_ptr_reg <= part_off_reg;
                  part_end_reg <= part_limit;
                  state_reg <= utx_pkg::ST_SEND;
               end
            end
            utx_pkg::ST_SEND: begin
               rd_ptr_reg <= rd_ptr_reg + 1'b1;
               if (send_end) begin
                  if (ev_done) begin
                     part_off_reg <= '0;
                     state_reg <= utx_pkg::ST_IDLE;
                  end else if (more_parts) begin
                     part_off_reg <= part_end_reg; // next part waits for a token
                     state_reg <= utx_pkg::ST_IDLE;
                  end else begin
                     state_reg <= utx_pkg::ST_WAIT;
                  end
               end
            end
            utx_pkg::ST_WAIT: begin
               if (ev_done) begin
                  part_off_reg <= '0;
                  state_reg <= utx_pkg::ST_IDLE;
               end else if (ev_nak || ev_none) begin
                  state_reg <= utx_pkg::ST_IDLE; // host retries
               end else if (periph && link.in_token) begin
                  rd_ptr_reg <= part_off_reg; // host asked again, resend
                  state_reg <= utx_pkg::ST_SEND;
               end
            end
            default: state_reg <= utx_pkg::ST_IDLE;
         endcase
      end
   end

   // ************************************************
   // link, dma and register read outputs
   // ************************************************
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         link.tx_valid <= 1'b0;
         link.tx_data <= 8'h00;
         link.tx_last <= 1'b0;
         link.tx_toggle <= 1'b0;
         link.stall_hs <= 1'b0;
         tx_event_out <= 1'b0;
      end else begin
         link.tx_valid <= state_reg == utx_pkg::ST_SEND && !flush_all;
         link.tx_data <= pkt_mem[rd_ptr_reg[AW-1:0]];
         link.tx_last <= send_end;
         link.tx_toggle <= toggle_reg;
         link.stall_hs <= ev_stall_tx;
         tx_event_out <= ev_done || cpu_flush || ev_err;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         dma_req_out <= 1'b0;
      end else begin
         dma_req_out <= dma_en_reg && dir_reg && !ready_reg && !flush_all
            && !(host_role_in && stall_flag_reg)
            && (dma_mode_reg ? load_ready_out : cnt_reg == '0);
      end
   end

   // read view follows the current role
   always_comb begin
      csr_view = {auto_reg, iso_reg && periph, dir_reg, dma_en_reg, frc_reg, dma_mode_reg,
         2'b00, incomp_reg, 1'b0, stall_flag_reg, stall_req_reg && periph, 1'b0,
         under_reg, ready_reg, ready_reg};
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 16'h0000;
      end else begin
         case (reg_sel_in)
            utx_pkg::REG_TX_MAXP: reg_rdata_out <= maxp_reg;
            utx_pkg::REG_TX_CSR: reg_rdata_out <= csr_view;
            utx_pkg::REG_RX_MAXP: reg_rdata_out <= rx_max_packet_reg;
            default: reg_rdata_out <= 16'h0000;
         endcase
      end
   end
endmodule : utx_dev

// ==== common/utx_pkg.sv ====
// shared constants and types for the tx endpoint control block and its partner
package utx_pkg;
   // ************************************************
   // register selection
   // ************************************************
   localparam logic [1:0] REG_TX_MAXP = 2'h0;
   localparam logic [1:0] REG_TX_CSR = 2'h1;
   localparam logic [1:0] REG_RX_MAXP = 2'h2;

   // ************************************************
   // max packet fields
   // ************************************************
   localparam int MP_PAY_HI = 10;
   localparam int MP_MULT_LO = 11;
   localparam int MP_MULT_HI = 12;
   localparam logic [15:0] MP_MASK = 16'h1fff;
   localparam logic [15:0] MP_RESET = 16'h0000;

   // ************************************************
   // control and status bit positions
   // ************************************************
   localparam int CSR_AUTO = 15;
   localparam int CSR_ISO = 14;
   localparam int CSR_DIR = 13;
   localparam int CSR_DMA_EN = 12;
   localparam int CSR_FRC_TOG = 11;
   localparam int CSR_DMA_MODE = 10;
   localparam int CSR_INCOMP = 7;
   localparam int CSR_CLR_TOG = 6;
   localparam int CSR_STALL_FLAG = 5;
   localparam int CSR_STALL_REQ = 4;
   localparam int CSR_FLUSH = 3;
   localparam int CSR_UNDER = 2;
   localparam int CSR_NOT_EMPTY = 1;
   localparam int CSR_READY = 0;
   localparam logic [15:0] CSR_RESET = 16'h0000;

   // ************************************************
   // sizes and counts
   // ************************************************
   localparam int ERR_LIMIT = 3;
   localparam int BUF_BYTES = 4096;
   localparam int BUF_AW = 12;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 100;
   localparam int FRAME_NS = 1000000;
   localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;

   // ************************************************
   // partner answer codes and device states
   // ************************************************
   localparam logic [1:0] ANS_ACK = 2'h0;
   localparam logic [1:0] ANS_NAK = 2'h1;
   localparam logic [1:0] ANS_STALL = 2'h2;
   localparam logic [1:0] ANS_NONE = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_WAIT = 3'b100
   } utx_state_t;
endpackage : utx_pkg

// ==== common/utx_link_if.sv ====
// link between the tx endpoint and its usb partner
`timescale 1ns/1ps
interface utx_link_if;
   // endpoint to partner
   logic tx_valid;
   logic [7:0] tx_data;
   logic tx_last;
   logic tx_toggle;
   logic stall_hs;
   // partner to endpoint
   logic in_token;
   logic hs_ack;
   logic hs_nak;
   logic hs_stall;
   logic hs_none;
   logic frame_tick;

   modport dev (
      output tx_valid, tx_data, tx_last, tx_toggle, stall_hs,
      input in_token, hs_ack, hs_nak, hs_stall, hs_none, frame_tick
   );
   modport partner (
      input tx_valid, tx_data, tx_last, tx_toggle, stall_hs,
      output in_token, hs_ack, hs_nak, hs_stall, hs_none, frame_tick
   );
endinterface : utx_link_if

// ==== core/utx_fifo.sv ====
// small synchronous byte queue with valid and ready on both sides
`timescale 1ns/1ps
module utx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic clear_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [PW:0] count_reg, count_next;
   logic push, pop;

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_ptr_reg];

   // occupancy; a clear drops a push in the same cycle
   always_comb begin
      if (clear_in) begin
         count_next = '0;
      end else begin
         count_next = count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end

   // storage, pointers wrap since depth is a power of two
   always_ff @(posedge clock_in) begin
      if (push && !clear_in) begin
         mem[wr_ptr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in || clear_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

   // registered full and empty flags
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         count_reg <= '0;
         in_ready_out <= 1'b1;
         out_valid_out <= 1'b0;
      end else begin
         count_reg <= count_next;
         in_ready_out <= count_next != (PW + 1)'(DEPTH);
         out_valid_out <= count_next != '0;
      end
   end
endmodule : utx_fifo

// ==== core/utx_partner.sv ====
// usb partner end: issues tokens, frames and handshakes to the tx endpoint
`timescale 1ns/1ps
module utx_partner #(
   parameter int FRAME_CYCLES = utx_pkg::FRAME_CYCLES
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic resetn_in,
   // partner commands
   input wire logic dev_is_host_in,
   input wire logic in_req_in,
   input wire logic [1:0] answer_in,
   // received stream
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_last_out,
   output logic rx_toggle_out,
   output logic stall_seen_out,
   // usb link
   utx_link_if.partner link
);
   logic [31:0] frame_cnt_reg;
   logic pkt_end;

   assign pkt_end = link.tx_valid && link.tx_last;

   // frame counter drives the frame tick
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         frame_cnt_reg <= 32'h0000_0000;
         link.frame_tick <= 1'b0;
      end else if (frame_cnt_reg >= 32'(FRAME_CYCLES - 1)) begin
         frame_cnt_reg <= 32'h0000_0000;
         link.frame_tick <= 1'b1;
      end else begin
         frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
         link.frame_tick <= 1'b0;
      end
   end

   // tokens on request, handshakes after each packet end; only ack is given when the endpoint is not the host
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         link.in_token <= 1'b0;
         link.hs_ack <= 1'b0;
         link.hs_nak <= 1'b0;
         link.hs_stall <= 1'b0;
         link.hs_none <= 1'b0;
      end else begin
         link.in_token <= in_req_in && !dev_is_host_in;
         link.hs_ack <= pkt_end && answer_in == utx_pkg::ANS_ACK;
         link.hs_nak <= pkt_end && dev_is_host_in && answer_in == utx_pkg::ANS_NAK;
         link.hs_stall <= pkt_end && dev_is_host_in && answer_in == utx_pkg::ANS_STALL;
         link.hs_none <= pkt_end && dev_is_host_in && answer_in == utx_pkg::ANS_NONE;
      end
   end

   // received bytes handed to the user side
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         rx_valid_out <= 1'b0;
         rx_data_out <= 8'h00;
         rx_last_out <= 1'b0;
         rx_toggle_out <= 1'b0;
         stall_seen_out <= 1'b0;
      end else begin
         rx_valid_out <= link.tx_valid;
         rx_data_out <= link.tx_data;
         rx_last_out <= pkt_end;
         rx_toggle_out <= link.tx_toggle;
         stall_seen_out <= link.stall_hs;
      end
   end
endmodule : utx_partner

// ==== test/utx_link_checker.sv ====
// wire checks between the tx endpoint and its partner
`timescale 1ns/1ps
module utx_link_checker (
   // clock and reset
   input wire logic clock_in, resetn_in,
   // link signals
   input wire logic tx_valid, tx_last, tx_toggle, stall_hs,
   input wire logic in_token, hs_ack, hs_nak, hs_stall, hs_none
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   // stall handshake
   property p_stl_one; stall_hs |=> !stall_hs; endproperty
   a_stl_one: assert property (p_stl_one) else $error("stall too long");
   property p_stl_tok; stall_hs |-> $past(in_token); endproperty
   a_stl_tok: assert property (p_stl_tok) else $error("stall without token");
   property p_stl_dat; stall_hs |-> !tx_valid; endproperty
   a_stl_dat: assert property (p_stl_dat) else $error("stall with data");
   // packet framing
   property p_lst_val; tx_last |-> tx_valid; endproperty
   a_lst_val: assert property (p_lst_val) else $error("last while idle");
   property p_tog_hld; tx_valid && !tx_last |=> $stable(tx_toggle); endproperty
   a_tog_hld: assert property (p_tog_hld) else $error("toggle moved");
   property p_end_lst; $fell(tx_valid) |-> $past(tx_last); endproperty
   a_end_lst: assert property (p_end_lst) else $error("packet cut");
   // handshakes
   property p_hs_pos; hs_ack || hs_nak || hs_stall || hs_none |-> $past(tx_last); endproperty
   a_hs_pos: assert property (p_hs_pos) else $error("stray handshake");
   property p_hs_one; $onehot0({hs_ack, hs_nak, hs_stall, hs_none}); endproperty
   a_hs_one: assert property (p_hs_one) else $error("two handshakes");
endmodule : utx_link_checker

// ==== test/test_usb_tx_endpoint_control.sv ====
// self-checking bench for the tx endpoint and its partner
`timescale 1ns/1ps
module test_usb_tx_endpoint_control;
   logic clock_in, resetn_in = 0, host_role = 0, reg_wr = 0, load_valid = 0, in_req = 0;
   logic [1:0] reg_sel = '0, answer = '0;
   logic [7:0] load_data = '0, poll = 8'h02, rx_data;
   logic [15:0] wdata = '0, rdata;
   logic rx_valid, rx_last, rx_toggle, dma_req, tx_event, stall_seen, host_bulk = 1;
   logic [15:0] events = '0, stalls = '0;
   int num_errors = 0, compares = 0, n;
   // register rows: select, written, read back
   logic [33:0] rows [4] = '{{2'h0, 16'hffff, 16'h1fff}, {2'h2, 16'he404, 16'h0404},
      {2'h3, 16'h1234, 16'h0000}, {2'h1, 16'h2700, 16'h2400}};
   utx_link_if utx_link_if_i ();
   utx_dev utx_dev_i (.clock_in, .resetn_in, .host_role_in(host_role), .host_bulk_in(host_bulk),
      .tx_poll_interval_in(poll), .reg_sel_in(reg_sel), .reg_wr_in(reg_wr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .load_valid_in(load_valid),
      .load_data_in(load_data), .load_ready_out(), .dma_req_out(dma_req), .tx_event_out(tx_event),
      .link(utx_link_if_i));
   utx_partner #(.FRAME_CYCLES(20)) utx_partner_i (.clock_in, .resetn_in,
      .dev_is_host_in(host_role), .in_req_in(in_req), .answer_in(answer),
      .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_last_out(rx_last),
      .rx_toggle_out(rx_toggle), .stall_seen_out(stall_seen), .link(utx_link_if_i));
   utx_link_checker utx_link_checker_i (.clock_in, .resetn_in,
      .tx_valid(utx_link_if_i.tx_valid), .tx_last(utx_link_if_i.tx_last),
      .tx_toggle(utx_link_if_i.tx_toggle), .stall_hs(utx_link_if_i.stall_hs),
      .in_token(utx_link_if_i.in_token), .hs_ack(utx_link_if_i.hs_ack),
      .hs_nak(utx_link_if_i.hs_nak), .hs_stall(utx_link_if_i.hs_stall),
      .hs_none(utx_link_if_i.hs_none));
   task automatic complete_run();
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t ns: %h not %h", $time, seen, exp);
      end
   endtask : chk
   // one register write, then a quiet cycle
   task automatic wr(logic [1:0] s, logic [15:0] d);
      reg_sel = s;
      wdata = d;
      reg_wr = 1;
      @(posedge clock_in) #1 reg_wr = 0;
      @(posedge clock_in) #1;
   endtask : wr
   // read a register, polling a bounded time for flags to settle
   task automatic rd(logic [1:0] s, logic [15:0] exp);
      reg_sel = s;
      @(posedge clock_in) #1;
      for (n = 0; n < 300 && rdata !== exp; n++) @(posedge clock_in) #1;
      chk(rdata, exp);
   endtask : rd
   task automatic tok();
      in_req = 1;
      @(posedge clock_in) #1 in_req = 0;
      for (n = 0; n < 50 && rx_valid !== 1'h1; n++) @(posedge clock_in) #1;
   endtask : tok
   // offer two bytes to the queue on back to back edges
   task automatic ld();
      load_valid = 1;
      load_data = 8'h5a;
      @(posedge clock_in) #1 load_data = 8'ha5;
      @(posedge clock_in) #1 load_valid = 0;
      repeat (3) @(posedge clock_in) #1;
   endtask : ld
   // count one-cycle pulses mid-cycle, away from the launching edge
   always @(negedge clock_in) begin
      if (tx_event === 1'b1) events = events + 16'h0001;
      if (stall_seen === 1'b1) stalls = stalls + 16'h0001;
   end
   initial begin
      clock_in = 0;
      forever #50 clock_in = ~clock_in;
   end
   initial begin
      #300000;
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clock_in);
      #1 resetn_in = 1;
      rd(2'h1, utx_pkg::CSR_RESET);
      rd(2'h0, utx_pkg::MP_RESET);
      foreach (rows[i]) begin
         wr(rows[i][33:32], rows[i][31:16]);
         rd(rows[i][33:32], rows[i][15:0]);
      end
      chk({15'h0000, dma_req}, 16'h0000);
      // two byte packet, acked by the partner
      ld();
      wr(2'h1, 16'h3400);
      chk({15'h0000, dma_req}, 16'h0001);
      wr(2'h1, 16'h3000);
      chk({15'h0000, dma_req}, 16'h0000);
      wr(2'h1, 16'h2001);
      rd(2'h1, 16'h2003);
      tok();
      chk({8'h00, rx_data}, 16'h005a);
      @(posedge clock_in) #1;
      chk({7'h00, rx_last, rx_data}, 16'h01a5);
      rd(2'h1, 16'h2000);
      tok();
      rd(2'h1, 16'h2004);
      wr(2'h1, 16'h2000);
      rd(2'h1, 16'h2000);
      // toggle cleared with an empty packet
      wr(2'h1, 16'h2041);
      tok();
      chk({15'h0000, rx_toggle}, 16'h0000);
      rd(2'h1, 16'h2000);
      wr(2'h1, 16'h2010);
      tok();
      rd(2'h1, 16'h2030);
      wr(2'h1, 16'h2009);
      rd(2'h1, 16'h2000);
      // auto set on a full two byte packet of two one byte payloads, then a forced toggle with no handshake
      wr(2'h0, 16'h0801);
      wr(2'h1, 16'ha800);
      ld();
      rd(2'h1, 16'ha803);
      answer = 2'h1;
      tok();
      rd(2'h1, 16'ha800);
      // host role: silent, stalled and nak-limited attempts
      host_role = 1;
      wr(2'h1, 16'h6010);
      rd(2'h1, 16'h2000);
      answer = 2'h3;
      wr(2'h1, 16'h2001);
      rd(2'h1, 16'h2004);
      wr(2'h1, 16'h2000);
      answer = 2'h2;
      wr(2'h1, 16'h2001);
      rd(2'h1, 16'h2020);
      wr(2'h1, 16'h2000);
      answer = 2'h1;
      wr(2'h1, 16'h2001);
      rd(2'h1, 16'h2083);
      wr(2'h1, 16'h2008);
      rd(2'h1, 16'h2000);
      // interrupt type: every silent attempt flags no response
      host_bulk = 0;
      answer = 2'h3;
      wr(2'h1, 16'h2001);
      rd(2'h1, 16'h2084);
      chk(events, 16'h0007);
      chk(stalls, 16'h0001);
      complete_run();
   end
endmodule : test_usb_tx_endpoint_control
